//--- hw/ext_reg_store.sv
`timescale 1ns/1ps
// small single port store for the extended registers; read data registered
module ext_reg_store (
   // clock
   input  wire logic                                  mclk,
   // access
   input  wire logic                                  we,
   input  wire logic [hs_ctrl_pkg::ext_addr_bits-1:0] addr,
   input  wire logic [15:0]                           wdata,
   output logic      [15:0]                           rdata
);

   logic [15:0] mem [hs_ctrl_pkg::ext_words];

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // no reset on contents: storage array kept as plain memory
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule : ext_reg_store

//--- hw/hs_channel_ctrl_indirect_access.sv
`timescale 1ns/1ps
// How it works
// - override clear: settings derived from reference choice
// - override set: settings taken from manual fields
// - rate bit picks 156.25 or 312.5 MHz
// - bit 11 skips receive rate compensation
// - bit 10 skips transmit rate compensation
// - bit 3 bypasses serial side encoder
// - bit 2 bypasses serial side decoder
// - tolerance 00 uses standard sync hysteresis
// - 01/10/11 drop sync after 1/2/3 errors
// - control word resets to all zeros
// - window reads and writes the pointed register
// - pointer and window only in older format
// - extended registers direct or through window
module hs_channel_ctrl_indirect_access (
   // clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst,
   // management register port
   input  wire hs_ctrl_pkg::mgmt_req_type req,
   output logic                           rd_valid,
   output logic      [15:0]               rdata,
   // manual settings from the related control registers
   input  wire hs_ctrl_pkg::rate_set_type manual_set,
   // channel receive error stream
   input  wire logic                      sym_valid,
   input  wire logic                      sym_error,
   input  wire logic                      std_loss,
   // decoded controls
   output hs_ctrl_pkg::hs_ctrl_type       ctrl,
   output hs_ctrl_pkg::rate_set_type      rate_set,
   output logic                           sync_ok
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [15:0] control_q;
   logic [15:0] pointer_q;
   logic        rd_pend_q;
   logic        rd_ext_q;
   logic [15:0] rd_reg_q;
   logic [1:0]  err_run_q;
   logic [1:0]  err_run_d;
   logic [15:0] ext_rdata;

   // sync state of the serial receive channel
   typedef enum logic {
      sync_lost,
      sync_held
   } sync_state_type;

   sync_state_type sync_q;
   sync_state_type sync_d;

   // returns true when req targets the given offset
   function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
      hit = (a == o);
   endfunction : hit

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // the pointer pair exists only for the older frame format
   wire old_fmt    = !req.ext_frame;
   wire ctl_hit    = hit(req.addr, hs_ctrl_pkg::hs_control_offset);
   wire ptr_hit    = old_fmt && hit(req.addr, hs_ctrl_pkg::pointer_offset);
   wire win_hit    = old_fmt && hit(req.addr, hs_ctrl_pkg::window_offset);
   // extended frames reach the store directly by address
   wire direct_hit = req.ext_frame && !ctl_hit;
   wire store_sel  = win_hit || direct_hit;
   wire [15:0] store_addr16 = win_hit ? pointer_q : req.addr;
   wire [hs_ctrl_pkg::ext_addr_bits-1:0] store_addr =
      store_addr16[hs_ctrl_pkg::ext_addr_bits-1:0];
   wire store_we   = req.wr && store_sel;
   // plain register writes; the control word answers in either frame format
   wire ctl_we     = req.wr && ctl_hit;
   wire ptr_we     = req.wr && ptr_hit;

   // only the low pointer bits reach the store, so higher pointer values
   // alias onto the same words; the store has no reset of its own
   ext_reg_store u_store (
      .mclk  (mclk),
      .we    (store_we),
      .addr  (store_addr),
      .wdata (req.wdata),
      .rdata (ext_rdata)
   );

   // ------------------------------------------------------------
   // control and pointer registers
   // ------------------------------------------------------------
   // pointer only changes on its own write, never after window use
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         control_q <= hs_ctrl_pkg::hs_control_reset;
         pointer_q <= hs_ctrl_pkg::pointer_reset;
      end else begin
         if (ctl_we) begin
            control_q <= req.wdata;
         end
         if (ptr_we) begin
            pointer_q <= req.wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // read path: answer one cycle after the request
   // ------------------------------------------------------------
   // read selection; unmapped offsets of the older format read back zero
   wire        ctl_rd      = req.rd && ctl_hit;
   wire        ptr_rd      = req.rd && ptr_hit;
   wire        store_rd    = req.rd && store_sel;
   wire [15:0] reg_rd_word = ctl_rd ? control_q :
                             ptr_rd ? pointer_q : 16'h0000;

   // store data are registered, so every read waits one cycle alike
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_pend_q <= 1'b0;
         rd_ext_q  <= 1'b0;
         rd_reg_q  <= 16'h0000;
      end else begin
         rd_pend_q <= req.rd;
         rd_ext_q  <= store_rd;
         rd_reg_q  <= reg_rd_word;
      end
   end

   assign rd_valid = rd_pend_q;
   assign rdata    = rd_ext_q ? ext_rdata : rd_reg_q;

   // ------------------------------------------------------------
   // decoded controls
   // ------------------------------------------------------------
   assign ctrl.reference_clock_input_auto_override       = control_q[hs_ctrl_pkg::override_bit];
   assign ctrl.reference_clock_input_rate_choice         = control_q[hs_ctrl_pkg::rate_bit];
   assign ctrl.rx_rate_comp_skip          = control_q[hs_ctrl_pkg::rx_comp_bit];
   assign ctrl.tx_rate_comp_skip          = control_q[hs_ctrl_pkg::tx_comp_bit];
   assign ctrl.serial_side_encoder_skip   = control_q[hs_ctrl_pkg::enc_skip_bit];
   assign ctrl.serial_side_decoder_skip   = control_q[hs_ctrl_pkg::dec_skip_bit];
   assign ctrl.serial_sync_loss_tolerance =
      hs_ctrl_pkg::hyst_type'(control_q[hs_ctrl_pkg::hyst_lsb+:2]);

   // automatic table lookup unless overridden; the registered output lags a
   // control write by one cycle, so the channel never sees a half-updated set
   wire hs_ctrl_pkg::rate_set_type auto_set = ctrl.reference_clock_input_rate_choice ?
      hs_ctrl_pkg::auto_312 : hs_ctrl_pkg::auto_156;
   wire hs_ctrl_pkg::rate_set_type next_set = ctrl.reference_clock_input_auto_override ?
      manual_set : auto_set;

   // data output from flip-flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rate_set <= hs_ctrl_pkg::auto_156;
      end else begin
         rate_set <= next_set;
      end
   end

   // ------------------------------------------------------------
   // sync loss tolerance
   // ------------------------------------------------------------
   // counts adjacent errors; a clean symbol clears the run. the run wraps
   // past three, which is harmless: the widest tolerance has dropped sync
   // by then, and out of sync the run is held at zero.
   wire [1:0] run_next   = sym_error ? 2'(err_run_q + 2'h1) : 2'h0;
   wire       run_one    = err_run_q >= 2'h1;
   wire       run_two    = err_run_q >= 2'h2;

   // drop decision per tolerance, weighed only on a valid symbol.
   // standard mode defers to the external standard machine loss flag.
   wire hs_ctrl_pkg::hyst_type tol = ctrl.serial_sync_loss_tolerance;
   wire       drop_std   = std_loss;
   wire       drop_one   = sym_error;
   wire       drop_two   = sym_error && run_one;
   wire       drop_three = sym_error && run_two;
   wire       drop_now   = (tol == hs_ctrl_pkg::hyst_standard) ? drop_std :
                           (tol == hs_ctrl_pkg::hyst_one)      ? drop_one :
                           (tol == hs_ctrl_pkg::hyst_two)      ? drop_two : drop_three;

   // a lost channel regains on the first clean symbol; a held one
   // weighs every valid symbol against the tolerance setting
   always_comb begin
      err_run_d = err_run_q;
      sync_d    = sync_q;
      case (sync_q)
         sync_lost: begin
            err_run_d = 2'h0;
            if (sym_valid && !sym_error) begin
               sync_d = sync_held;
            end
         end
         sync_held: begin
            if (sym_valid) begin
               err_run_d = run_next;
               if (drop_now) begin
                  sync_d = sync_lost;
               end
            end
         end
         default: begin
            err_run_d = 2'h0;
            sync_d    = sync_lost;
         end
      endcase
   end

   // state and run counter
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         err_run_q <= 2'h0;
         sync_q    <= sync_lost;
      end else begin
         err_run_q <= err_run_d;
         sync_q    <= sync_d;
      end
   end

   assign sync_ok = (sync_q == sync_held);

endmodule : hs_channel_ctrl_indirect_access

//--- hw/hs_ctrl_pkg.sv
package hs_ctrl_pkg;

   // ------------------------------------------------------------
   // register offsets on the management register port
   // ------------------------------------------------------------
   localparam logic [15:0] hs_control_offset = 16'h001d;
   localparam logic [15:0] pointer_offset    = 16'h001e;
   localparam logic [15:0] window_offset     = 16'h001f;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] hs_control_reset  = 16'h0000;
   localparam logic [15:0] pointer_reset     = 16'h0000;

   // ------------------------------------------------------------
   // field positions of the channel control word
   // ------------------------------------------------------------
   localparam int override_bit   = 13;
   localparam int rate_bit       = 12;
   localparam int rx_comp_bit    = 11;
   localparam int tx_comp_bit    = 10;
   localparam int enc_skip_bit   = 3;
   localparam int dec_skip_bit   = 2;
   localparam int hyst_lsb       = 0;

   // ------------------------------------------------------------
   // extended register store
   // ------------------------------------------------------------
   localparam int ext_addr_bits  = 8;
   localparam int ext_words      = 256;

   // sync loss tolerance settings
   typedef enum logic [1:0] {
      hyst_standard = 2'h0,
      hyst_one      = 2'h1,
      hyst_two      = 2'h2,
      hyst_three    = 2'h3
   } hyst_type;

   // decoded controls handed to the channel datapath
   typedef struct packed {
      logic     reference_clock_input_auto_override;
      logic     reference_clock_input_rate_choice;
      logic     rx_rate_comp_skip;
      logic     tx_rate_comp_skip;
      logic     serial_side_encoder_skip;
      logic     serial_side_decoder_skip;
      hyst_type serial_sync_loss_tolerance;
   } hs_ctrl_type;

   // multiplier and rate settings in force
   typedef struct packed {
      logic [7:0] fast_pll_multiplier;
      logic [7:0] slow_side_multiplier;
      logic [3:0] tx_rate;
      logic [3:0] rx_rate;
   } rate_set_type;

   // automatic settings per reference clock choice (plain defaults)
   localparam rate_set_type auto_156 = '{8'h42, 8'h10, 4'h1, 4'h1};
   localparam rate_set_type auto_312 = '{8'h21, 8'h08, 4'h1, 4'h1};

   // management register access
   typedef struct packed {
      logic        ext_frame;   // extended frame format in use
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mgmt_req_type;

endpackage : hs_ctrl_pkg

//--- verification/hs_ctrl_props.sv
`timescale 1ns/1ps
// port checker for the channel control block; all checks sleep while reset is high
module hs_ctrl_props (
   // clock and reset
   input wire logic                      mclk,
   input wire logic                      rst,
   // management port and settings
   input wire hs_ctrl_pkg::mgmt_req_type req,
   input wire logic                      rd_valid,
   input wire logic [15:0]               rdata,
   input wire hs_ctrl_pkg::rate_set_type manual_set,
   // receive error stream and results
   input wire logic                      sym_valid,
   input wire logic                      sym_error,
   input wire logic                      std_loss,
   input wire hs_ctrl_pkg::hs_ctrl_type  ctrl,
   input wire hs_ctrl_pkg::rate_set_type rate_set,
   input wire logic                      sync_ok
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // an error counts only on a valid symbol
   wire logic                  bad;
   wire hs_ctrl_pkg::hyst_type tol;
   assign bad = sym_valid && sym_error;
   assign tol = ctrl.serial_sync_loss_tolerance;
   chk_read_answer: assert property (req.rd |=> rd_valid)
      else $error("read not answered");
   chk_ctrl_decode: assert property (
      req.wr && req.addr == hs_ctrl_pkg::hs_control_offset
      |=> ctrl == {$past(req.wdata[13:10]), $past(req.wdata[3:0])})
      else $error("control bits not decoded");
   chk_auto_slow: assert property (
      !ctrl.reference_clock_input_auto_override && !ctrl.reference_clock_input_rate_choice
      |=> rate_set == hs_ctrl_pkg::auto_156) else $error("slow auto set wrong");
   chk_auto_fast: assert property (
      !ctrl.reference_clock_input_auto_override && ctrl.reference_clock_input_rate_choice
      |=> rate_set == hs_ctrl_pkg::auto_312) else $error("fast auto set wrong");
   chk_manual_path: assert property (
      ctrl.reference_clock_input_auto_override
      |=> rate_set == $past(manual_set)) else $error("manual set ignored");
   chk_one_error: assert property (
      sync_ok && bad && tol == hs_ctrl_pkg::hyst_one
      |=> !sync_ok) else $error("single error kept sync");
   chk_two_errors: assert property (
      (sync_ok && bad && tol == hs_ctrl_pkg::hyst_two) [*2]
      |=> !sync_ok) else $error("two errors kept sync");
   chk_three_errors: assert property (
      (sync_ok && bad && tol == hs_ctrl_pkg::hyst_three) [*3]
      |=> !sync_ok) else $error("three errors kept sync");
   chk_std_loss: assert property (
      sync_ok && sym_valid && std_loss && tol == hs_ctrl_pkg::hyst_standard
      |=> !sync_ok) else $error("loss ignored");
   // main scenarios reached
   cover property (req.rd && !req.ext_frame && req.addr == hs_ctrl_pkg::window_offset);
   cover property (ctrl.reference_clock_input_auto_override);
   cover property (sync_ok ##1 !sync_ok);
endmodule : hs_ctrl_props
bind hs_channel_ctrl_indirect_access hs_ctrl_props props (.mclk, .rst, .req, .rd_valid,
   .rdata, .manual_set, .sym_valid, .sym_error, .std_loss, .ctrl, .rate_set, .sync_ok);

//--- verification/mgmt_station.sv
`timescale 1ns/1ps
// management station model; strobes stand for exactly the edge that takes them
module mgmt_station (
   // clock
   input  wire logic                 mclk,
   // register port
   output hs_ctrl_pkg::mgmt_req_type req,
   input  wire logic                 rd_valid,
   input  wire logic [15:0]          rdata
);
   initial req = '0;
   // after the strobe, address and data turn to their inverse so nothing stale looks valid
   task automatic xfer(input logic ext, input logic w, input logic [15:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      int n = 0;
      @(posedge mclk);
      req <= '{ext, w, !w, a, d};
      @(posedge mclk);
      req <= '{ext, 1'b0, 1'b0, ~a, ~d};
      #1;
      while (!w && rd_valid !== 1'b1 && n < 4) begin
         @(posedge mclk);
         #1;
         n++;
      end
      q = rdata;
   endtask : xfer
   // older format: pointer first, then the window
   task automatic via_window(input logic w, input logic [15:0] a, input logic [15:0] d,
                             output logic [15:0] q);
      xfer(1'b0, 1'b1, hs_ctrl_pkg::pointer_offset, a, q);
      xfer(1'b0, w, hs_ctrl_pkg::window_offset, d, q);
   endtask : via_window
endmodule : mgmt_station

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic                      mclk;
   logic                      rst = 1'b1;
   hs_ctrl_pkg::mgmt_req_type req;
   logic                      rd_valid;
   logic [15:0]               rdata;
   hs_ctrl_pkg::rate_set_type manual_set = '{8'h5a, 8'h3c, 4'h7, 4'h2};
   logic                      sym_valid = 1'b0;
   logic                      sym_error = 1'b0;
   logic                      std_loss = 1'b0;
   hs_ctrl_pkg::hs_ctrl_type  ctrl;
   hs_ctrl_pkg::rate_set_type rate_set;
   logic                      sync_ok;
   int                        error_cnt = 0;
   int                        samples_checked = 0;
   int                        cycles = 0;
   logic [15:0]               q;
   logic [15:0]               vals [9] = '{16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0008,
                                           16'h0004, 16'h0002, 16'h0003, 16'hc3f1};
   mgmt_station st (.mclk, .req, .rd_valid, .rdata);
   hs_channel_ctrl_indirect_access dut (.mclk, .rst, .req, .rd_valid, .rdata, .manual_set,
      .sym_valid, .sym_error, .std_loss, .ctrl, .rate_set, .sync_ok);
   // ------------------------------------------------------------
   // clock, watchdog and report
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // the tests need well under a thousand cycles; the ceiling leaves room
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         $display("timeout after %0d cycles", cycles);
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // a burst of adjacent symbols, then one idle edge that takes the last of them
   task automatic syms(input int n, input logic e, input logic loss);
      repeat (n) begin
         @(posedge mclk);
         sym_valid <= 1'b1;
         sym_error <= e;
         std_loss  <= loss;
      end
      @(posedge mclk);
      sym_valid <= 1'b0;
      sym_error <= 1'b0;
      std_loss  <= 1'b0;
      #1;
   endtask : syms
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      st.xfer(1'b0, 1'b0, hs_ctrl_pkg::hs_control_offset, 16'h0000, q);
      check("control after reset", 16'h0000, q);
      check("read answer", 1'b1, rd_valid);
      st.xfer(1'b0, 1'b0, hs_ctrl_pkg::pointer_offset, 16'h0000, q);
      check("pointer after reset", 16'h0000, q);
      check("rate after reset", hs_ctrl_pkg::auto_156, rate_set);
      $display("test reset done");
      foreach (vals[i]) begin
         st.xfer(1'b0, 1'b1, hs_ctrl_pkg::hs_control_offset, vals[i], q);
         st.xfer(1'b0, 1'b0, hs_ctrl_pkg::hs_control_offset, 16'h0000, q);
         check("control word", vals[i], q);
         check("decoded", {vals[i][13:10], vals[i][3:0]}, ctrl);
         check("rate set", vals[i][13] ? manual_set : vals[i][12] ? hs_ctrl_pkg::auto_312
               : hs_ctrl_pkg::auto_156, rate_set);
      end
      $display("test control done");
      st.via_window(1'b1, 16'h0005, 16'habcd, q);
      st.via_window(1'b1, 16'h0006, 16'h1234, q);
      st.via_window(1'b0, 16'h0005, 16'h0000, q);
      check("window read", 16'habcd, q);
      st.xfer(1'b0, 1'b0, hs_ctrl_pkg::window_offset, 16'h0000, q);
      check("window again", 16'habcd, q);
      st.xfer(1'b1, 1'b0, 16'h0006, 16'h0000, q);
      check("direct read", 16'h1234, q);
      st.xfer(1'b1, 1'b1, hs_ctrl_pkg::pointer_offset, 16'h0077, q);
      st.xfer(1'b1, 1'b0, hs_ctrl_pkg::pointer_offset, 16'h0000, q);
      check("direct slot", 16'h0077, q);
      st.xfer(1'b0, 1'b0, hs_ctrl_pkg::pointer_offset, 16'h0000, q);
      check("pointer kept", 16'h0005, q);
      st.xfer(1'b0, 1'b0, 16'h0010, 16'h0000, q);
      check("unmapped read", 16'h0000, q);
      $display("test indirect done");
      for (int m = 0; m < 4; m++) begin
         st.xfer(1'b0, 1'b1, hs_ctrl_pkg::hs_control_offset, 16'(m), q);
         syms(1, 1'b0, 1'b0);
         check("sync regained", 1'b1, sync_ok);
         syms(m == 0 ? 3 : m - 1, 1'b1, 1'b0);
         check("sync held", 1'b1, sync_ok);
         syms(1, 1'b0, 1'b0);
         syms(m == 0 ? 1 : m, 1'b1, m == 0);
         check("sync lost", 1'b0, sync_ok);
      end
      $display("test sync done");
      conclude();
   end
endmodule : testbench
